/* isf_params.svh */
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// coprocessor selector of a read
`define ISF_CP_NUM        4'hf
`define ISF_OPC1          3'h0
`define ISF_CRN           4'h0
`define ISF_CRM           4'h2
`define ISF_OPC2_C        3'h3
`define ISF_OPC2_D        3'h4

// processor mode codes
`define ISF_MODE_USR      5'h10

// third feature register fields
`define ISF_C_EEX_HI      31
`define ISF_C_EEX_LO      28
`define ISF_C_EEX_VAL     4'h1
`define ISF_C_NOP_HI      27
`define ISF_C_NOP_LO      24
`define ISF_C_NOP_VAL     4'h1
`define ISF_C_CPY_HI      23
`define ISF_C_CPY_LO      20
`define ISF_C_CPY_VAL     4'h1
`define ISF_C_TBR_HI      19
`define ISF_C_TBR_LO      16
`define ISF_C_TBR_VAL     4'h1
`define ISF_C_EXC_HI      15
`define ISF_C_EXC_LO      12
`define ISF_C_EXC_VAL     4'h2
`define ISF_C_SVC_HI      11
`define ISF_C_SVC_LO      8
`define ISF_C_SVC_VAL     4'h1
`define ISF_C_SMD_HI      7
`define ISF_C_SMD_LO      4
`define ISF_C_SMD_VAL     4'h3
`define ISF_C_SAT_HI      3
`define ISF_C_SAT_LO      0
`define ISF_C_SAT_VAL     4'h1

// fourth feature register fields
`define ISF_D_RSV_HI      31
`define ISF_D_RSV_LO      24
`define ISF_D_RSV_VAL     8'h00
`define ISF_D_SYN_HI      23
`define ISF_D_SYN_LO      20
`define ISF_D_SYN_VAL     4'h0
`define ISF_D_BAR_HI      19
`define ISF_D_BAR_LO      16
`define ISF_D_BAR_VAL     4'h1
`define ISF_D_SMC_HI      15
`define ISF_D_SMC_LO      12
`define ISF_D_SMC_VAL     4'h1
`define ISF_D_WBK_HI      11
`define ISF_D_WBK_LO      8
`define ISF_D_WBK_VAL     4'h1
`define ISF_D_SHF_HI      7
`define ISF_D_SHF_LO      4
`define ISF_D_SHF_VAL     4'h4
`define ISF_D_UNP_HI      3
`define ISF_D_UNP_LO      0
`define ISF_D_UNP_VAL     4'h2

`define ISF_ZERO32        32'h0000_0000

`endif

/* isf_pkg.sv */
package isf_pkg;
   // which feature register a read selects
   typedef enum logic [1:0] {
      ISF_SEL_NONE,
      ISF_SEL_C,
      ISF_SEL_D
   } isf_sel_e;

   // answer kind of one read
   typedef enum logic [1:0] {
      ISF_ANS_IDLE,
      ISF_ANS_DATA,
      ISF_ANS_UNDEF,
      ISF_ANS_MISS
   } isf_ans_e;
endpackage

/* isf_decode.sv */
`include "isf_params.svh"

module isf_decode (
   // read selector
   input  wire logic [3:0]         i_cp_num,
   input  wire logic [2:0]         i_opc1,
   input  wire logic [3:0]         i_crn,
   input  wire logic [3:0]         i_crm,
   input  wire logic [2:0]         i_opc2,
   // result
   output isf_pkg::isf_sel_e       o_sel
);
   logic base_hit;

   // common part of both selectors
   assign base_hit = (i_cp_num == `ISF_CP_NUM) && (i_opc1 == `ISF_OPC1)
                     && (i_crn == `ISF_CRN) && (i_crm == `ISF_CRM);

   // opcode2 picks the register
   always_comb begin
      o_sel = isf_pkg::ISF_SEL_NONE;
      if (base_hit && (i_opc2 == `ISF_OPC2_C)) begin
         o_sel = isf_pkg::ISF_SEL_C; // [RQ3]
      end else if (base_hit && (i_opc2 == `ISF_OPC2_D)) begin
         o_sel = isf_pkg::ISF_SEL_D; // [RQ4]
      end
   end
endmodule

/* isf_values.sv */
`include "isf_params.svh"

module isf_values (
   // constant contents
   output logic [31:0]             o_feat_c,
   output logic [31:0]             o_feat_d
);
   // third register, fixed wiring
   always_comb begin
      o_feat_c = `ISF_ZERO32;
      o_feat_c[`ISF_C_EEX_HI:`ISF_C_EEX_LO] = `ISF_C_EEX_VAL; // [RQ5]
      o_feat_c[`ISF_C_NOP_HI:`ISF_C_NOP_LO] = `ISF_C_NOP_VAL; // [RQ6]
      o_feat_c[`ISF_C_CPY_HI:`ISF_C_CPY_LO] = `ISF_C_CPY_VAL; // [RQ7]
      o_feat_c[`ISF_C_TBR_HI:`ISF_C_TBR_LO] = `ISF_C_TBR_VAL; // [RQ8]
      o_feat_c[`ISF_C_EXC_HI:`ISF_C_EXC_LO] = `ISF_C_EXC_VAL; // [RQ9]
      o_feat_c[`ISF_C_SVC_HI:`ISF_C_SVC_LO] = `ISF_C_SVC_VAL;
      o_feat_c[`ISF_C_SMD_HI:`ISF_C_SMD_LO] = `ISF_C_SMD_VAL;
      o_feat_c[`ISF_C_SAT_HI:`ISF_C_SAT_LO] = `ISF_C_SAT_VAL; // [RQ10]
   end

   // fourth register, fixed wiring
   always_comb begin
      o_feat_d = `ISF_ZERO32;
      o_feat_d[`ISF_D_RSV_HI:`ISF_D_RSV_LO] = `ISF_D_RSV_VAL; // [RQ11]
      o_feat_d[`ISF_D_SYN_HI:`ISF_D_SYN_LO] = `ISF_D_SYN_VAL; // [RQ11]
      o_feat_d[`ISF_D_BAR_HI:`ISF_D_BAR_LO] = `ISF_D_BAR_VAL; // [RQ12]
      o_feat_d[`ISF_D_SMC_HI:`ISF_D_SMC_LO] = `ISF_D_SMC_VAL; // [RQ13]
      o_feat_d[`ISF_D_WBK_HI:`ISF_D_WBK_LO] = `ISF_D_WBK_VAL; // [RQ14]
      o_feat_d[`ISF_D_SHF_HI:`ISF_D_SHF_LO] = `ISF_D_SHF_VAL; // [RQ15]
      o_feat_d[`ISF_D_UNP_HI:`ISF_D_UNP_LO] = `ISF_D_UNP_VAL; // [RQ16]
   end
endmodule

/* isf_regs.sv */
// Function
// [RQ1] reads only allowed in privileged modes
// [RQ2] one copy for secure and non-secure
// [RQ3] third register at 0,c0,c2,3
// [RQ4] fourth register at 0,c0,c2,4
// [RQ5] third bits 31:28 read 0x1
// [RQ6] third bits 27:24 read 0x1
// [RQ7] third bits 23:20 read 0x1
// [RQ8] third bits 19:16 read 0x1
// [RQ9] third bits 15:12 read 0x2
// [RQ10] third bits 3:0 read 0x1
// [RQ11] fourth bits 31:20 read zero
// [RQ12] fourth bits 19:16 read 0x1
// [RQ13] fourth bits 15:12 read 0x1
// [RQ14] fourth bits 11:8 read 0x1
// [RQ15] fourth bits 7:4 read 0x4
// [RQ16] fourth bits 3:0 read 0x2
// [RQ17] constant contents, writes have no effect
// [RQ18] unprivileged read raises undefined instruction
`include "isf_params.svh"

module isf_regs (
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_arst_n,
   // coprocessor access request
   input  wire logic               i_req,
   input  wire logic               i_wr,
   input  wire logic [3:0]         i_cp_num,
   input  wire logic [2:0]         i_opc1,
   input  wire logic [3:0]         i_crn,
   input  wire logic [3:0]         i_crm,
   input  wire logic [2:0]         i_opc2,
   input  wire logic [31:0]        i_wdata,
   // processor state
   input  wire logic [4:0]         i_mode,
   input  wire logic               i_ns,
   // answer
   output logic                    o_ack,
   output logic [31:0]             o_rdata,
   output logic                    o_undef,
   output logic                    o_hit
);
   isf_pkg::isf_sel_e   sel;
   isf_pkg::isf_ans_e   ans_nxt;
   logic [31:0]         feat_c;
   logic [31:0]         feat_d;
   logic [31:0]         rdata_nxt;
   logic                priv;
   logic                ack_r;
   logic [31:0]         rdata_r;
   logic                undef_r;
   logic                hit_r;

   // selector decode
   isf_decode u_decode (
      .i_cp_num (i_cp_num),
      .i_opc1   (i_opc1),
      .i_crn    (i_crn),
      .i_crm    (i_crm),
      .i_opc2   (i_opc2),
      .o_sel    (sel)
   );

   // constant register contents, no clock or reset
   isf_values u_values (
      .o_feat_c (feat_c), // [RQ17]
      .o_feat_d (feat_d)
   );

   // privilege check, security state ignored
   assign priv = (i_mode != `ISF_MODE_USR); // [RQ2]

   // answer classification
   always_comb begin
      ans_nxt   = isf_pkg::ISF_ANS_IDLE;
      rdata_nxt = `ISF_ZERO32;
      if (i_req) begin
         if (sel == isf_pkg::ISF_SEL_NONE) begin
            ans_nxt = isf_pkg::ISF_ANS_MISS;
         end else if (!priv || i_wr) begin
            ans_nxt = isf_pkg::ISF_ANS_UNDEF; // [RQ1] [RQ18] [RQ17]
         end else begin
            ans_nxt = isf_pkg::ISF_ANS_DATA;
            unique case (sel)
               isf_pkg::ISF_SEL_C: rdata_nxt = feat_c; // [RQ2]
               isf_pkg::ISF_SEL_D: rdata_nxt = feat_d; // [RQ2]
               default:            rdata_nxt = `ISF_ZERO32;
            endcase
         end
      end
   end

   // acknowledge one cycle after request
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= i_req;
      end
   end

   // selection hit flag
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= (ans_nxt == isf_pkg::ISF_ANS_DATA) || (ans_nxt == isf_pkg::ISF_ANS_UNDEF);
      end
   end

   // undefined-instruction signal
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         undef_r <= 1'b0;
      end else begin
         undef_r <= (ans_nxt == isf_pkg::ISF_ANS_UNDEF); // [RQ18]
      end
   end

   // read data, zero unless a granted read
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= `ISF_ZERO32;
      end else begin
         rdata_r <= rdata_nxt; // [RQ1]
      end
   end

   assign o_ack   = ack_r;
   assign o_rdata = rdata_r;
   assign o_undef = undef_r;
   assign o_hit   = hit_r;

   // write data and security bit have no effect
   logic unused_ok;
   assign unused_ok = ^{i_wdata, i_ns};
endmodule

/* isf_regs_asserts.sv */
module isf_regs_chk (
   // clock, reset and request
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_req,
   input  wire logic        i_wr,
   input  wire logic [3:0]  i_cp_num,
   input  wire logic [2:0]  i_opc1,
   input  wire logic [3:0]  i_crn,
   input  wire logic [3:0]  i_crm,
   input  wire logic [2:0]  i_opc2,
   input  wire logic [4:0]  i_mode,
   // answer
   input  wire logic        o_ack,
   input  wire logic [31:0] o_rdata,
   input  wire logic        o_undef,
   input  wire logic        o_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   // selector decode
   wire logic base = i_cp_num == 4'hf && i_opc1 == 3'h0 && i_crn == 4'h0 && i_crm == 4'h2;
   wire logic hc   = i_req && base && i_opc2 == 3'h3;
   wire logic hd   = i_req && base && i_opc2 == 3'h4;
   wire logic ok   = !i_wr && i_mode != 5'h10;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   a_c_value:
   assert property (hc && ok |=> o_ack && o_hit && !o_undef && o_rdata == 32'h1111_2131)
      else $error("third register read wrong");
   a_d_value:
   assert property (hd && ok |=> o_ack && o_hit && !o_undef && o_rdata == 32'h0001_1142)
      else $error("fourth register read wrong");
   a_user_undef:
   assert property ((hc || hd) && !i_wr && i_mode == 5'h10 |=> o_undef && o_hit && o_rdata == 32'h0)
      else $error("user read not refused");
   a_write_refused:
   assert property ((hc || hd) && i_wr |=> o_undef && o_hit && o_rdata == 32'h0)
      else $error("write not refused");
   a_miss_quiet:
   assert property (i_req && !hc && !hd |=> o_ack && !o_hit && !o_undef && o_rdata == 32'h0)
      else $error("unmatched selector answered wrongly");
   a_idle_quiet:
   assert property (!i_req |=> !o_ack && !o_hit && !o_undef && o_rdata == 32'h0)
      else $error("answer without request");
   a_ack_follows:
   assert property (i_req |=> o_ack)
      else $error("request not acknowledged");
   a_hold_value:
   assert property (hc && ok ##1 hc && ok |=> o_rdata == $past(o_rdata))
      else $error("third register changed");
endmodule

bind isf_regs isf_regs_chk chk_u (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_wr(i_wr), .i_cp_num(i_cp_num),
   .i_opc1(i_opc1), .i_crn(i_crn), .i_crm(i_crm), .i_opc2(i_opc2), .i_mode(i_mode),
   .o_ack(o_ack), .o_rdata(o_rdata), .o_undef(o_undef), .o_hit(o_hit)
);

/* isf_regs_tb_top.sv */
module isf_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // driven and observed signals
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        i_req = 1'b0;
   logic        i_wr = 1'b0;
   logic [3:0]  i_cp_num = 4'h0;
   logic [2:0]  i_opc1 = 3'h0;
   logic [3:0]  i_crn = 4'h0;
   logic [3:0]  i_crm = 4'h0;
   logic [2:0]  i_opc2 = 3'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [4:0]  i_mode = 5'h13;
   logic        i_ns = 1'b0;
   logic        o_ack;
   logic        o_undef;
   logic        o_hit;
   logic [31:0] o_rdata;
   int          fails = 0;
   int          n_checks = 0;
   int          cyc = 0;
   localparam logic [31:0] VC = 32'h1111_2131;
   localparam logic [31:0] VD = 32'h0001_1142;
   isf_regs dut_u (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_wr(i_wr), .i_cp_num(i_cp_num),
      .i_opc1(i_opc1), .i_crn(i_crn), .i_crm(i_crm), .i_opc2(i_opc2), .i_wdata(i_wdata),
      .i_mode(i_mode), .i_ns(i_ns), .o_ack(o_ack), .o_rdata(o_rdata), .o_undef(o_undef),
      .o_hit(o_hit)
   );
   // clock
   initial begin
      forever #2 i_clk = ~i_clk;
   end
   // hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         fails++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic good, input string msg);
      n_checks++;
      if (good !== 1'b1) begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // one access, answer checked a cycle later
   task automatic acc(input logic [3:0] cp, input logic [3:0] crm, input logic [2:0] op2,
                      input logic wr, input logic [4:0] md, input logic ns,
                      input logic hit, input logic und, input logic [31:0] dat);
      i_req = 1'b1;
      i_cp_num = cp;
      i_crm = crm;
      i_opc2 = op2;
      i_wr = wr;
      i_mode = md;
      i_ns = ns;
      @(posedge i_clk);
      #1;
      chk(o_ack === 1'b1 && o_hit === hit && o_undef === und && o_rdata === dat, "answer");
   endtask
   task automatic idle();
      i_req = 1'b0;
      @(posedge i_clk);
      #1;
      chk(o_ack === 1'b0 && o_hit === 1'b0 && o_undef === 1'b0 && o_rdata === 32'h0, "idle");
   endtask
   // main sequence, back to back accesses
   initial begin
      repeat (10) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h13, 1'b0, 1'b1, 1'b0, VC);
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h1f, 1'b1, 1'b1, 1'b0, VC);
      acc(4'hf, 4'h2, 3'h4, 1'b0, 5'h13, 1'b1, 1'b1, 1'b0, VD);
      acc(4'hf, 4'h2, 3'h4, 1'b0, 5'h11, 1'b0, 1'b1, 1'b0, VD);
      acc(4'hf, 4'h2, 3'h4, 1'b0, 5'h10, 1'b0, 1'b1, 1'b1, 32'h0);
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h10, 1'b1, 1'b1, 1'b1, 32'h0);
      i_wdata = 32'hffff_ffff;
      acc(4'hf, 4'h2, 3'h3, 1'b1, 5'h13, 1'b0, 1'b1, 1'b1, 32'h0);
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h13, 1'b0, 1'b1, 1'b0, VC);
      acc(4'hf, 4'h2, 3'h5, 1'b0, 5'h13, 1'b0, 1'b0, 1'b0, 32'h0);
      acc(4'he, 4'h2, 3'h3, 1'b0, 5'h13, 1'b0, 1'b0, 1'b0, 32'h0);
      acc(4'hf, 4'h1, 3'h4, 1'b0, 5'h13, 1'b0, 1'b0, 1'b0, 32'h0);
      // wrong opcode1, then wrong primary register
      i_opc1 = 3'h1;
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h13, 1'b0, 1'b0, 1'b0, 32'h0);
      i_opc1 = 3'h0;
      i_crn = 4'h1;
      acc(4'hf, 4'h2, 3'h4, 1'b0, 5'h13, 1'b0, 1'b0, 1'b0, 32'h0);
      i_crn = 4'h0;
      idle();
      // reset while a granted read stands, request kept high
      acc(4'hf, 4'h2, 3'h3, 1'b0, 5'h13, 1'b0, 1'b1, 1'b0, VC);
      i_arst_n = 1'b0;
      @(posedge i_clk);
      #1;
      chk(o_ack === 1'b0 && o_hit === 1'b0 && o_rdata === 32'h0, "reset");
      i_arst_n = 1'b1;
      acc(4'hf, 4'h2, 3'h4, 1'b0, 5'h13, 1'b0, 1'b1, 1'b0, VD);
      idle();
      give_verdict();
   end
endmodule
